// ---- logic/tcp_pkg.sv ----
// Package for the 8-bit timer/counter with shared prescaler.
// Assumes a 32-bit AHB-Lite register bus at 20 MHz.
package tcp_pkg;
   localparam int unsigned TCP_CLK_HZ = 20000000;
   // Register byte offsets
   localparam logic [7:0] TCP_OFS_COUNT = 8'h00;
   localparam logic [7:0] TCP_OFS_OPTION = 8'h04;
   localparam logic [7:0] TCP_OFS_INTCTL = 8'h08;
   localparam logic [7:0] TCP_OFS_STATUS = 8'h0c;
   localparam logic [7:0] TCP_OFS_MASK = 8'h10;
   localparam logic [7:0] TCP_OFS_SLEEP = 8'h14;
   // Option field positions
   localparam int unsigned TCP_BIT_CSS = 5;
   localparam int unsigned TCP_BIT_SES = 4;
   localparam int unsigned TCP_BIT_ASSIGN = 3;
   localparam int unsigned TCP_BIT_PS_LO = 0;
   // Interrupt control field positions
   localparam int unsigned TCP_BIT_OVF = 2;
   localparam int unsigned TCP_BIT_OIE = 5;
   // Reset values
   localparam logic [7:0] TCP_RST_OPTION = 8'hff;
   localparam logic [7:0] TCP_RST_COUNT = 8'h00;
   localparam logic [7:0] TCP_RST_INTCTL = 8'h00;
   // Cycles counting is held off after a count write
   localparam logic [1:0] TCP_WRITE_HOLD = 2'h2;
   // AHB constants
   localparam logic [1:0] TCP_HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic clock_source_select;
      logic source_edge_select;
      logic prescaler_assign;
      logic [2:0] prescale_rate;
   } tcp_option_t;

   typedef enum logic [1:0] {TCP_ST_RUN, TCP_ST_HOLD} tcp_state_t;
endpackage

// ---- logic/tcp_edge_sync.sv ----
// Two-flop synchroniser with selectable edge detect for the count pin.
// Assumes the pin is asynchronous to hclk.
`timescale 1ns/1ns
`default_nettype none
module tcp_edge_sync
   import tcp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin,
   input wire logic fall_sel,
   output logic edge_pulse
);
   logic meta;
   logic sync;
   logic last;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
      end
      else
      begin
         meta <= pin;
         sync <= meta;
         last <= sync;
      end
   end

   // Sampled once per cycle, so short pulses may be missed
   always_comb
   begin
      edge_pulse = fall_sel ? (last & ~sync) : (~last & sync);
   end

   AST_EDGE_DIR: assert property (@(posedge hclk) disable iff (!hresetn)
      edge_pulse |-> sync == !fall_sel && $past(sync) == fall_sel)
      else $error("edge of the wrong direction");
endmodule
`default_nettype wire

// ---- logic/tcp_prescaler.sv ----
// Shared 8-bit prescaler; divides count events by 2 to 256.
// Assumes a one-cycle event input from the same clock.
`timescale 1ns/1ns
`default_nettype none
module tcp_prescaler
   import tcp_pkg::*;
#(
   parameter int unsigned WIDTH = 8
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clear,
   input wire logic event_in,
   input wire logic [2:0] rate,
   output logic tick
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] top;

   // Count stays internal; no bus path reaches it
   always_comb
   begin
      top = WIDTH'((2 << rate) - 1);
      tick = event_in && (count == top);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         count <= '0;
      else if (clear || tick)
         count <= '0;
      else if (event_in)
         count <= count + 1'b1;
   end
endmodule
`default_nettype wire

// ---- logic/tcp_timer.sv ----
// Behaviour
// - 8-bit counter increments each cycle unprescaled
// - Option bit 5 selects timer or pin
// - Counter write holds counting two cycles
// - Option bit 4 picks rising or falling
// - Option bit 3 routes prescaler away
// - Prescaler count is never software visible
// - Prescaler divides 1:2 through 1:256
// - Wrap to zero sets overflow flag
// - Overflow interrupt gated by enable bit
// - Counter stops during sleep
// - Pin sampled per cycle; short pulses lost
//
// Top of the timer/counter: AHB-Lite slave, counter, overflow logic.
// Assumes a single AHB-Lite master and sleep driven from the core.
`timescale 1ns/1ns
`default_nettype none
module tcp_timer
   import tcp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ext_count_pin,
   input wire logic sleep_in,
   output logic irq
);
   tcp_option_t option;
   logic [7:0] timer_count_reg;
   logic overflow_flag;
   logic overflow_int_enable;
   logic status;
   logic mask;
   logic sleep_q1;
   logic sleep_mode;
   logic [1:0] hold_cnt;
   tcp_state_t state;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic pin_edge;
   logic src_event;
   logic pre_tick;
   logic inc;
   logic wrap;
   logic wr_count;
   logic wr_option;
   logic wr_intctl;
   logic wr_status;
   logic wr_mask;
   logic rd_sel;
   logic [31:0] next_hrdata;

   // Data-phase write strobe for one register offset
   function automatic logic wr_hit
   (
      input logic pend,
      input logic [7:0] addr,
      input logic [7:0] ofs
   );
      return pend && (addr == ofs);
   endfunction

   tcp_edge_sync u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(ext_count_pin),
      .fall_sel(option.source_edge_select),
      .edge_pulse(pin_edge)
   );

   // Source event: instruction cycle or pin edge
   always_comb
   begin
      src_event = option.clock_source_select ? pin_edge : 1'b1;
   end

   tcp_prescaler #(.WIDTH(8)) u_pre (
      .hclk(hclk),
      .hresetn(hresetn),
      .clear(option.prescaler_assign || wr_count),
      .event_in(src_event && !option.prescaler_assign && !sleep_mode),
      .rate(option.prescale_rate),
      .tick(pre_tick)
   );

   // One counter step per qualified source event
   always_comb
   begin
      inc = !sleep_mode && (state == TCP_ST_RUN) && !wr_count
         && (option.prescaler_assign ? src_event : pre_tick);
      wrap = inc && (timer_count_reg == 8'hff);
   end

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend <= hsel && htrans[1] && hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   always_comb
   begin
      wr_count = wr_hit(wr_pend, wr_addr, TCP_OFS_COUNT);
      wr_option = wr_hit(wr_pend, wr_addr, TCP_OFS_OPTION);
      wr_intctl = wr_hit(wr_pend, wr_addr, TCP_OFS_INTCTL);
      wr_status = wr_hit(wr_pend, wr_addr, TCP_OFS_STATUS);
      wr_mask = wr_hit(wr_pend, wr_addr, TCP_OFS_MASK);
      rd_sel = hready && hsel && htrans[1] && !hwrite;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         option <= tcp_option_t'(TCP_RST_OPTION[5:0]);
      else if (wr_option)
         option <= tcp_option_t'(hwdata[5:0]);
   end

   // Sleep level synchronised from the core
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sleep_q1 <= 1'b0;
         sleep_mode <= 1'b0;
      end
      else
      begin
         sleep_q1 <= sleep_in;
         sleep_mode <= sleep_q1;
      end
   end

   // Count write hold-off
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= TCP_ST_RUN;
         hold_cnt <= 2'h0;
      end
      else
      begin
         case (state)
            TCP_ST_RUN:
            begin
               if (wr_count)
               begin
                  state <= TCP_ST_HOLD;
                  hold_cnt <= TCP_WRITE_HOLD - 2'h1;
               end
            end
            TCP_ST_HOLD:
            begin
               if (wr_count)
                  hold_cnt <= TCP_WRITE_HOLD - 2'h1;
               else if (hold_cnt == 2'h0)
                  state <= TCP_ST_RUN;
               else
                  hold_cnt <= hold_cnt - 2'h1;
            end
            default:
               state <= TCP_ST_RUN;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         timer_count_reg <= TCP_RST_COUNT;
      else if (wr_count)
         timer_count_reg <= hwdata[7:0];
      else if (inc)
         timer_count_reg <= timer_count_reg + 8'h01;
   end

   // Overflow flag: hardware set wins over software clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         overflow_flag <= 1'b0;
         overflow_int_enable <= 1'b0;
      end
      else
      begin
         if (wrap)
            overflow_flag <= 1'b1;
         else if (wr_intctl)
            overflow_flag <= hwdata[TCP_BIT_OVF];
         if (wr_intctl)
            overflow_int_enable <= hwdata[TCP_BIT_OIE];
      end
   end

   // Sticky status, write one to clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         status <= 1'b0;
         mask <= 1'b0;
      end
      else
      begin
         if (wrap)
            status <= 1'b1;
         else if (wr_status && hwdata[0])
            status <= 1'b0;
         if (wr_mask)
            mask <= hwdata[0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq <= 1'b0;
      else
         irq <= (overflow_flag && overflow_int_enable) || (status && mask);
   end

   // Read mux, decoded from the address phase
   always_comb
   begin
      next_hrdata = 32'h0000_0000;
      case (haddr[7:0])
         TCP_OFS_COUNT: next_hrdata[7:0] = timer_count_reg;
         TCP_OFS_OPTION: next_hrdata[7:0] = {2'b11, option};
         TCP_OFS_INTCTL:
         begin
            next_hrdata[TCP_BIT_OVF] = overflow_flag;
            next_hrdata[TCP_BIT_OIE] = overflow_int_enable;
         end
         TCP_OFS_STATUS: next_hrdata[0] = status;
         TCP_OFS_MASK: next_hrdata[0] = mask;
         TCP_OFS_SLEEP: next_hrdata[0] = sleep_mode;
         default: next_hrdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (rd_sel)
            hrdata <= next_hrdata;
      end
   end

   // Checks on counting, hold-off, flags and the bus
   AST_WRITE_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_count |=> !inc [*2])
      else $error("count moved during write hold");

   AST_HOLD_VALUE: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_count ##1 !wr_count |-> timer_count_reg == $past(hwdata[7:0])
      ##1 timer_count_reg == $past(hwdata[7:0], 2))
      else $error("written count not held");

   AST_HOLD_RESUME: assert property (@(posedge hclk) disable iff (!hresetn)
      state == TCP_ST_HOLD && hold_cnt == 2'h0 && !wr_count |=> state == TCP_ST_RUN)
      else $error("hold-off did not end");

   AST_WRAP_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
      wrap |=> overflow_flag && timer_count_reg == 8'h00)
      else $error("wrap did not set flag");

   AST_WRAP_STATUS: assert property (@(posedge hclk) disable iff (!hresetn)
      wrap |=> status)
      else $error("wrap did not set status");

   AST_FLAG_HELD: assert property (@(posedge hclk) disable iff (!hresetn)
      overflow_flag && !wr_intctl |=> overflow_flag)
      else $error("flag cleared by hardware");

   AST_IRQ_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
      (overflow_flag && overflow_int_enable) |=> irq)
      else $error("enabled overflow did not raise irq");

   AST_IRQ_MASK: assert property (@(posedge hclk) disable iff (!hresetn)
      !(overflow_flag && overflow_int_enable) && !(status && mask) |=> !irq)
      else $error("masked overflow raised irq");

   AST_SLEEP_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
      sleep_mode && !wr_count |=> $stable(timer_count_reg))
      else $error("counter moved in sleep");

   AST_SLEEP_PRE: assert property (@(posedge hclk) disable iff (!hresetn)
      sleep_mode |-> !pre_tick)
      else $error("prescaler ticked in sleep");

   AST_TIMER_NOPRE: assert property (@(posedge hclk) disable iff (!hresetn)
      !option.clock_source_select && option.prescaler_assign && !sleep_mode
      && state == TCP_ST_RUN && !wr_count
      |=> timer_count_reg == $past(timer_count_reg) + 8'h01)
      else $error("timer did not step");

   AST_PRE_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
      !option.prescaler_assign && !pre_tick |-> !inc)
      else $error("prescaled count stepped without tick");

   AST_PRE_ROUTE: assert property (@(posedge hclk) disable iff (!hresetn)
      option.prescaler_assign |-> !pre_tick)
      else $error("prescaler ticked while assigned away");

   AST_PIN_MODE: assert property (@(posedge hclk) disable iff (!hresetn)
      option.clock_source_select && option.prescaler_assign && !pin_edge
      |=> $stable(timer_count_reg) || $past(wr_count))
      else $error("counter mode stepped without pin edge");

   AST_PIN_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
      option.clock_source_select && option.prescaler_assign && pin_edge && !sleep_mode
      && state == TCP_ST_RUN && !wr_count
      |=> timer_count_reg == $past(timer_count_reg) + 8'h01)
      else $error("pin edge not counted");

   AST_BUS_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp)
      else $error("bus response not ready and okay");
endmodule
`default_nettype wire

// ---- tb/tcp_pin_src.sv ----
// Count-pin source: a burst of level toggles on request, then still.
// Assumes hclk from the bench and a one-cycle go pulse.
`timescale 1ns/1ns
`default_nettype none
module tcp_pin_src
(
   input wire logic hclk,
   input wire logic go,
   input wire logic slow,
   input wire logic [3:0] n_tog,
   output logic pin
);
   int left = 0;
   int wait_c = 0;
   initial pin = 1'b0;
   always @(posedge hclk)
   begin
      if (go)
      begin
         left <= n_tog;
         wait_c <= 0;
      end
      else if (left > 0)
      begin
         // Each level held 3 or 7 cycles so sampling cannot miss it
         if (wait_c == (slow ? 6 : 2))
         begin
            pin <= ~pin;
            left <= left - 1;
            wait_c <= 0;
         end
         else
            wait_c <= wait_c + 1;
      end
   end
endmodule
`default_nettype wire

// ---- tb/tcp_timer_tb.sv ----
// Self-checking bench for the timer/counter over AHB-Lite.
// Assumes one AHB-Lite slave; its hreadyout is the bus hready.
`timescale 1ns/1ns
`default_nettype none
module tcp_timer_tb;
   import tcp_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sleep_in = 0, go = 0, slow = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, d, a;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic hready, hresp, irq, pin;
   logic [3:0] n_tog = 0;
   int n_mismatch = 0, n_tests = 0, v, p, lvl;
   always #25 hclk = ~hclk;
   tcp_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .ext_count_pin(pin),
      .sleep_in(sleep_in), .irq(irq));
   tcp_pin_src src_u (.hclk(hclk), .go(go), .slow(slow), .n_tog(n_tog), .pin(pin));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One single transfer; read data lands in d
   task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, ad};
      hwrite <= wr;
      htrans <= TCP_HTRANS_NONSEQ;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      d = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
      bus(1'b0, ad, 0);
      check(d, exp);
   endtask
   task automatic irqchk(input logic [7:0] ad, input logic [31:0] wd, input logic exp);
      bus(1'b1, ad, wd);
      repeat (2) @(posedge hclk);
      check(32'(irq), 32'(exp));
   endtask
   task automatic end_of_test;
      if (n_mismatch == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge hclk);
      n_mismatch++;
      end_of_test;
   end
   initial
   begin
      void'($urandom(39021));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check(32'(hresp), 0);
      check(32'(hready), 1);
      rdchk(TCP_OFS_OPTION, 32'hff);
      rdchk(TCP_OFS_COUNT, 0);
      bus(1'b1, 8'h20, '1);
      rdchk(8'h20, 0);
      bus(1'b1, TCP_OFS_OPTION, 32'h08);
      for (int g = 0; g < 6; g++)
      begin
         v = 'hf8 + $urandom_range(6);
         bus(1'b1, TCP_OFS_COUNT, v);
         repeat (g) @(posedge hclk);
         rdchk(TCP_OFS_COUNT, (v + (g > 2 ? g - 2 : 0)) & 'hff);
      end
      // Rate 8 means prescaler assigned away
      for (int i = 0; i < 9; i++)
      begin
         p = (i == 8) ? 1 : 2 << i;
         bus(1'b1, TCP_OFS_OPTION, (i == 8) ? 32'h08 : i);
         bus(1'b0, TCP_OFS_COUNT, 0);
         a = d;
         repeat (p * 4 - 2) @(posedge hclk);
         rdchk(TCP_OFS_COUNT, (a + 4) & 'hff);
      end
      // Last pass counts rising pin edges through the 1:2 prescaler
      for (int k = 0; k < 5; k++)
      begin
         v = (k >> 1) & 1;
         slow <= 1'($urandom_range(1));
         bus(1'b1, TCP_OFS_OPTION, ((k == 4) ? 32'h20 : 32'h28) | (v << 4));
         bus(1'b0, TCP_OFS_COUNT, 0);
         a = d;
         lvl = pin;
         n_tog <= 4'h9;
         go <= 1'b1;
         @(posedge hclk);
         go <= 1'b0;
         repeat (80) @(posedge hclk);
         rdchk(TCP_OFS_COUNT, (a + ((k == 4) ? 2 : ((lvl ^ v) ? 4 : 5))) & 'hff);
      end
      bus(1'b1, TCP_OFS_OPTION, 32'h08);
      bus(1'b1, TCP_OFS_COUNT, 0);
      bus(1'b1, TCP_OFS_INTCTL, 0);
      bus(1'b1, TCP_OFS_MASK, 0);
      bus(1'b1, TCP_OFS_STATUS, 1);
      bus(1'b1, TCP_OFS_COUNT, 32'hfe);
      repeat (8) @(posedge hclk);
      check(32'(irq), 0);
      rdchk(TCP_OFS_INTCTL, 32'h04);
      rdchk(TCP_OFS_STATUS, 1);
      irqchk(TCP_OFS_INTCTL, 32'h24, 1'b1);
      irqchk(TCP_OFS_INTCTL, 32'h20, 1'b0);
      irqchk(TCP_OFS_MASK, 1, 1'b1);
      irqchk(TCP_OFS_STATUS, 1, 1'b0);
      rdchk(TCP_OFS_STATUS, 0);
      bus(1'b0, TCP_OFS_COUNT, 0);
      a = d;
      sleep_in <= 1'b1;
      repeat (20) @(posedge hclk);
      rdchk(TCP_OFS_SLEEP, 1);
      repeat (18) @(posedge hclk);
      sleep_in <= 1'b0;
      repeat (10) @(posedge hclk);
      rdchk(TCP_OFS_COUNT, (a + 12) & 'hff);
      end_of_test;
   end
endmodule
`default_nettype wire
